// >>> logic/elp_arbiter.sv
// fixed priority pick among hardware interrupt sources
// assumes requests already qualified by enables and the global mask
`timescale 1ns/1ps
module elp_arbiter (
	elp_core_if.arb core
);
	// lowest source number wins, so scan from the top of the numbering downward and let the last hit stand
	always_comb begin
		core.pick_vld = 1'b0;
		core.pick_idx = 4'h0;
		for (int i = 15; i >= 1; i--) begin
			if (core.req[i]) begin
				core.pick_vld = 1'b1;
				core.pick_idx = 4'(i);
			end
		end
		core.pick_vec = elp_pkg::elp_hw_vec(core.pick_idx);
	end
endmodule // elp_arbiter

// >>> logic/elp_core_if.sv
// carrier between the control top and its arbiter and recovery counter
// assumes one clock domain; the interface holds no logic
`timescale 1ns/1ps
interface elp_core_if;
	logic [15:1] req; // enabled, present requests
	logic pick_vld; // some request is pending
	logic [3:0] pick_idx; // winning source number
	logic [15:0] pick_vec; // its vector address
	logic cnt_clr; // hold recovery counter at zero
	logic cnt_run; // let recovery counter advance
	logic cnt_short; // short recovery selected
	logic cnt_done; // recovery time elapsed
	modport arb (input req, output pick_vld, output pick_idx, output pick_vec);
	modport cnt (input cnt_clr, input cnt_run, input cnt_short, output cnt_done);
	modport top (output req, output cnt_clr, output cnt_run, output cnt_short,
		input pick_vld, input pick_idx, input pick_vec, input cnt_done);
endinterface

// >>> logic/elp_ctrl.sv
// exception and low-power control: arbitration, vectors, mask, break, wait/stop
// assumes cpu strobes are one-cycle pulses synchronous to clk (the 4x bus clock)
//
// What this block does
// - latched interrupt holds until serviced or mask cleared
// - entry pushes registers, sets mask; return restores
// - check requests only at instruction boundaries
// - highest priority pending source served first
// - fixed vector pairs per source
// - global mask gates hardware sources only; swi, break and reset pass
// - software interrupt taken unless reset in the same cycle
// - software pushes pc, hardware pushes pc minus one
// - one status flag per maskable source
// - flag reads one while request present
// - status one bits 0,1,3 read zero
// - resets highest priority, bypass arbitration
// - break forces software interrupt vector fetch
// - break protects flags unless clear enable set
// - flag cleared in break stays cleared
// - two-step clears protected across break entry
// - wait or stop gates cpu, clears mask
// - wait keeps peripheral clocks, interrupt wakes cpu
// - reset or break exits wait, break sets flag
// - stop clears counter, gates clocks, recovery delay
// - osc on during stop keeps 4x clock
// - recovery 4096 cycles, or 32 when short
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module elp_ctrl #(
	parameter int STOP_REC_CYC = elp_pkg::STOP_REC_LONG // shorten in simulation
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [15:1] src_req,
	input wire logic [15:1] src_en,
	input wire logic rst_req,
	input wire logic brk_req,
	input wire logic instr_done,
	input wire logic swi_exec,
	input wire logic wait_exec,
	input wire logic stop_exec,
	input wire logic rti_exec,
	input wire logic rti_mask,
	input wire logic cli_exec,
	output logic int_start,
	output logic [15:0] int_vec,
	output logic push_pc_dec,
	output logic mask_bit,
	output logic break_state,
	output logic flag_clr_ok,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic clk_x2_en,
	output logic clk_x4_en
);
	elp_core_if core (); // arbiter and counter carrier

	elp_pkg::elp_pwr_t pwr_q; // power state
	elp_pkg::elp_pwr_t pwr_d;
	logic mask_q; // global interrupt mask
	logic lat_vld_q; // an interrupt is latched
	logic [15:0] lat_vec_q; // its vector
	logic brk_pend_q; // break waiting for a boundary
	logic brk_q; // cpu in break state
	logic break_flag_clear_enable_q; // break_flag_clear_enable
	logic short_stop_recovery_q; // short_stop_recovery
	logic oscstop_q; // osc_on_during_stop
	logic break_stop_wait_flag_q; // break_stop_wait_flag
	logic wake_go_q; // first boundary after wakeup
	logic start_q; // entry pulse
	logic [15:0] vec_q; // entry vector
	logic pcdec_q; // entry pushes pc minus one
	logic [7:0] rdata_q; // read data register
	logic [15:1] live; // present sources only
	logic [15:1] armed; // enabled and unmasked
	logic boundary; // instruction boundary seen
	logic wake; // low-power exit request
	logic hw_take; // latched interrupt enters now
	logic brk_take; // break enters now
	logic swi_take; // software interrupt enters now

	// strip sources that do not exist
	assign live = src_req & elp_pkg::SRC_PRESENT;
	// enable per source, then the global mask; swi never passes here
	assign armed = mask_q ? '0 : (live & src_en);
	assign core.req = armed;
	// wakeup counts as a boundary so stacking starts right after
	assign boundary = instr_done | wake_go_q;
	// software interrupt ignores the mask
	assign swi_take = swi_exec & ~rst_req;
	assign brk_take = brk_pend_q & boundary & ~rst_req & ~swi_take;
	// latched hardware entry yields only to reset, swi and break
	assign hw_take = lat_vld_q & pwr_q == elp_pkg::ELP_RUN & ~rst_req
		& ~swi_take & ~brk_take;
	// enabled interrupt or break leaves low power
	assign wake = (|(live & src_en)) | brk_pend_q | brk_req;

	elp_arbiter u_arb (
		.core(core)
	);

	elp_rec_counter #(
		.LONG_CYC(STOP_REC_CYC)
	) u_rec (
		.clk(clk),
		.nrst(nrst),
		.core(core)
	);

	// counter held at zero through stop, runs only in recovery
	assign core.cnt_clr = pwr_q == elp_pkg::ELP_STOP;
	assign core.cnt_run = pwr_q == elp_pkg::ELP_RECOV;
	assign core.cnt_short = short_stop_recovery_q;

	// power state transitions
	always_comb begin
		pwr_d = pwr_q;
		unique case (pwr_q)
			elp_pkg::ELP_RUN: begin
				if (wait_exec) begin
					pwr_d = elp_pkg::ELP_WAIT;
				end else if (stop_exec) begin
					pwr_d = elp_pkg::ELP_STOP;
				end
			end
			elp_pkg::ELP_WAIT: begin
				// peripherals still clocked, so their requests can wake us
				if (wake) begin
					pwr_d = elp_pkg::ELP_RUN;
				end
			end
			elp_pkg::ELP_STOP: begin
				if (wake) begin
					pwr_d = elp_pkg::ELP_RECOV;
				end
			end
			elp_pkg::ELP_RECOV: begin
				// stacking waits for the oscillator to settle
				if (core.cnt_done) begin
					pwr_d = elp_pkg::ELP_RUN;
				end
			end
		endcase
		// any reset leaves low power at once
		if (rst_req) begin
			pwr_d = elp_pkg::ELP_RUN;
		end
	end

	// power state register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pwr_q <= elp_pkg::ELP_RUN;
		end else begin
			pwr_q <= pwr_d;
		end
	end

	// one-shot boundary when the cpu gets its clock back
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wake_go_q <= 1'b0;
		end else begin
			wake_go_q <= pwr_q != elp_pkg::ELP_RUN && pwr_d == elp_pkg::ELP_RUN && !rst_req;
		end
	end

	// clock gating from the power state
	always_comb begin
		cpu_clk_en = pwr_q == elp_pkg::ELP_RUN;
		// peripherals keep running in wait only
		periph_clk_en = pwr_q == elp_pkg::ELP_RUN || pwr_q == elp_pkg::ELP_WAIT;
		clk_x2_en = periph_clk_en;
		// recovery needs the 4x clock to time itself
		clk_x4_en = pwr_q != elp_pkg::ELP_STOP || oscstop_q;
	end

	// latch one hardware interrupt at a boundary
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lat_vld_q <= 1'b0;
			lat_vec_q <= 16'h0000;
		end else if (rst_req) begin
			lat_vld_q <= 1'b0;
		end else if (hw_take) begin
			lat_vld_q <= 1'b0; // serviced
		end else if (cli_exec && lat_vld_q) begin
			// mask cleared: a new arbitration may pick another
			lat_vld_q <= 1'b0;
		end else if (!lat_vld_q && boundary && core.pick_vld && !swi_take) begin
			// later higher requests cannot displace this one
			lat_vld_q <= 1'b1;
			lat_vec_q <= core.pick_vec;
		end
	end

	// break request waits for a boundary or wakes low power
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			brk_pend_q <= 1'b0;
		end else if (rst_req || brk_take) begin
			brk_pend_q <= 1'b0;
		end else if (brk_req) begin
			brk_pend_q <= 1'b1;
		end
	end

	// break state, left on return from the break handler
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			brk_q <= 1'b0;
		end else if (rst_req) begin
			brk_q <= 1'b0;
		end else if (brk_take) begin
			brk_q <= 1'b1;
		end else if (rti_exec) begin
			brk_q <= 1'b0;
		end
	end

	// global interrupt mask
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mask_q <= 1'b1;
		end else if (rst_req || swi_take || brk_take || hw_take) begin
			mask_q <= 1'b1; // blocks further interrupts
		end else if (pwr_q == elp_pkg::ELP_RUN && (wait_exec || stop_exec)) begin
			mask_q <= 1'b0; // lets interrupts wake the cpu
		end else if (rti_exec) begin
			mask_q <= rti_mask; // stacked value restored
		end else if (cli_exec) begin
			mask_q <= 1'b0;
		end
	end

	// entry pulse with vector and stacked pc form
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			start_q <= 1'b0;
			vec_q <= 16'h0000;
			pcdec_q <= 1'b0;
		end else begin
			start_q <= rst_req | swi_take | brk_take | hw_take;
			if (rst_req) begin
				vec_q <= elp_pkg::VEC_RESET; // no arbitration
				pcdec_q <= 1'b0;
			end else if (swi_take) begin
				vec_q <= elp_pkg::VEC_SWI;
				pcdec_q <= 1'b0; // pc as is
			end else if (brk_take) begin
				vec_q <= elp_pkg::VEC_SWI;
				pcdec_q <= 1'b1;
			end else if (hw_take) begin
				vec_q <= lat_vec_q;
				pcdec_q <= 1'b1;
			end
		end
	end

	// software registers, source status registers ignore writes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			break_flag_clear_enable_q <= elp_pkg::BRK_FLAG_CTL_RST[elp_pkg::BREAK_FLAG_CLEAR_ENABLE_POS];
			short_stop_recovery_q <= elp_pkg::CFG_ONE_RST[elp_pkg::SHORT_STOP_RECOVERY_POS];
			oscstop_q <= elp_pkg::CFG_ONE_RST[elp_pkg::OSCSTOP_POS];
		end else if (reg_wr) begin
			unique case (reg_addr)
				elp_pkg::OFS_BRK_FLAG_CTL: begin
					break_flag_clear_enable_q <= reg_wdata[elp_pkg::BREAK_FLAG_CLEAR_ENABLE_POS];
				end
				elp_pkg::OFS_CFG_ONE: begin
					short_stop_recovery_q <= reg_wdata[elp_pkg::SHORT_STOP_RECOVERY_POS];
					oscstop_q <= reg_wdata[elp_pkg::OSCSTOP_POS];
				end
				default: begin
					// status and unmapped words take no write
				end
			endcase
		end
	end

	// break in wait or stop sets the flag; set beats a same-cycle clear
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			break_stop_wait_flag_q <= elp_pkg::BRK_STATUS_RST[elp_pkg::BREAK_STOP_WAIT_FLAG_POS];
		end else if (brk_take && wake_go_q) begin
			break_stop_wait_flag_q <= 1'b1;
		end else if (reg_wr && reg_addr == elp_pkg::OFS_BRK_STATUS && !reg_wdata[elp_pkg::BREAK_STOP_WAIT_FLAG_POS]) begin
			break_stop_wait_flag_q <= 1'b0;
		end
	end

	// read data for one cycle after the strobe, zero otherwise
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				elp_pkg::OFS_STAT_ONE: begin
					// live request levels, bits 0,1,3 fixed low
					rdata_q <= {live[6:3], 1'b0, live[1], 2'b00};
				end
				elp_pkg::OFS_STAT_TWO: begin
					rdata_q <= {live[14:9], 1'b0, live[7]};
				end
				elp_pkg::OFS_STAT_THREE: begin
					rdata_q <= {7'h00, live[15]};
				end
				elp_pkg::OFS_BRK_FLAG_CTL: begin
					rdata_q <= {break_flag_clear_enable_q, 7'h00};
				end
				elp_pkg::OFS_CFG_ONE: begin
					rdata_q <= {6'h00, oscstop_q, short_stop_recovery_q};
				end
				elp_pkg::OFS_BRK_STATUS: begin
					rdata_q <= {6'h00, break_stop_wait_flag_q, 1'b0};
				end
				default: begin
					rdata_q <= 8'h00; // unmapped reads zero
				end
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	// peripherals gate their clear strobes on this; a two-step clear whose
	// first step came before break still needs this high on its second
	// step, and a flag cleared here stays cleared since nothing restores it
	assign flag_clr_ok = !brk_q || break_flag_clear_enable_q;

	assign reg_rdata = rdata_q;
	assign int_start = start_q;
	assign int_vec = vec_q;
	assign push_pc_dec = pcdec_q;
	assign mask_bit = mask_q;
	assign break_state = brk_q;
endmodule // elp_ctrl

// >>> logic/elp_pkg.sv
// constants, types and helpers for the exception and low-power control block
// assumes an 8-bit register port with a 3-bit word address
package elp_pkg;
	// register word addresses
	localparam logic [2:0] OFS_STAT_ONE = 3'h0; // irq_source_status_one
	localparam logic [2:0] OFS_STAT_TWO = 3'h1; // irq_source_status_two
	localparam logic [2:0] OFS_STAT_THREE = 3'h2; // irq_source_status_three
	localparam logic [2:0] OFS_BRK_FLAG_CTL = 3'h3; // break_flag_control_reg
	localparam logic [2:0] OFS_CFG_ONE = 3'h4; // config_reg_one
	localparam logic [2:0] OFS_BRK_STATUS = 3'h5; // break_status_reg
	// field positions
	localparam int BREAK_FLAG_CLEAR_ENABLE_POS = 7; // break_flag_clear_enable
	localparam int SHORT_STOP_RECOVERY_POS = 0; // short_stop_recovery
	localparam int OSCSTOP_POS = 1; // osc_on_during_stop
	localparam int BREAK_STOP_WAIT_FLAG_POS = 1; // break_stop_wait_flag
	// reset values
	localparam logic [7:0] BRK_FLAG_CTL_RST = 8'h00;
	localparam logic [7:0] CFG_ONE_RST = 8'h00;
	localparam logic [7:0] BRK_STATUS_RST = 8'h00;
	// sources that exist, bit k-1 is source k
	localparam logic [14:0] SRC_PRESENT = 15'h7f7d;
	// stop recovery counts in bus_clock_times_four cycles
	localparam int STOP_REC_LONG = 4096;
	localparam int STOP_REC_SHORT = 32;
	localparam int REC_CNT_W = 13;
	// vector addresses (low byte of each pair)
	localparam logic [15:0] VEC_RESET = 16'hfffe;
	localparam logic [15:0] VEC_SWI = 16'hfffc;
	localparam logic [15:0] VEC_HW_BASE = 16'hfffc;
	// power sequencing states
	typedef enum logic [1:0] {
		ELP_RUN = 2'b00,
		ELP_WAIT = 2'b01,
		ELP_STOP = 2'b10,
		ELP_RECOV = 2'b11
	} elp_pwr_t;
	// hardware source index to vector, higher sources step down by pairs
	function automatic logic [15:0] elp_hw_vec(input logic [3:0] idx);
		elp_hw_vec = VEC_HW_BASE - {11'h000, idx, 1'b0};
	endfunction
endpackage

// >>> logic/elp_rec_counter.sv
// stop recovery counter
// assumes clr and run are never high together; clr wins if they are
`timescale 1ns/1ps
module elp_rec_counter #(
	parameter int LONG_CYC = elp_pkg::STOP_REC_LONG
) (
	input wire logic clk,
	input wire logic nrst,
	elp_core_if.cnt core
);
	logic [elp_pkg::REC_CNT_W-1:0] cnt_q; // elapsed recovery cycles
	logic [elp_pkg::REC_CNT_W-1:0] target; // cycles to wait
	// target picked live, so the setting in force on each recovery cycle is used
	assign target = core.cnt_short ? elp_pkg::REC_CNT_W'(elp_pkg::STOP_REC_SHORT)
		: elp_pkg::REC_CNT_W'(LONG_CYC);
	assign core.cnt_done = core.cnt_run && (cnt_q == target);
	// count while running, saturate at the target
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= '0;
		end else if (core.cnt_clr) begin
			cnt_q <= '0;
		end else if (core.cnt_run && cnt_q != target) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
endmodule // elp_rec_counter

// >>> sim/elp_cpu_model.sv
// behavioural cpu core beside the control block
// assumes a gated cpu clock: no boundaries while cpu_clk_en is low
`timescale 1ns/1ps
module elp_cpu_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic go,
	input wire logic cpu_clk_en,
	input wire logic int_start,
	output logic instr_done
);
	logic [1:0] cyc_q; // cycles into the current instruction
	// four-cycle instructions; entry restarts the count for stacking
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cyc_q <= 2'h0;
			instr_done <= 1'b0;
		end else if (int_start || !cpu_clk_en) begin
			cyc_q <= 2'h0; // halted or stacking, no boundary
			instr_done <= 1'b0;
		end else begin
			cyc_q <= cyc_q + 2'h1;
			instr_done <= go && cyc_q == 2'h3; // boundary on last cycle
		end
	end
endmodule // elp_cpu_model

// >>> sim/elp_ctrl_asserts.sv
// port assertions for the exception and low-power control
// assumes one clock domain; nrst low clears all state
`timescale 1ns/1ps
module elp_ctrl_asserts (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [2:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic rst_req,
	input wire logic swi_exec,
	input wire logic wait_exec,
	input wire logic stop_exec,
	input wire logic int_start,
	input wire logic [15:0] int_vec,
	input wire logic push_pc_dec,
	input wire logic mask_bit,
	input wire logic break_state,
	input wire logic flag_clr_ok,
	input wire logic cpu_clk_en,
	input wire logic periph_clk_en,
	input wire logic clk_x2_en,
	input wire logic clk_x4_en
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// software entry request not overridden by reset
	sequence s_swi_go;
		swi_exec && !rst_req;
	endsequence
	// low-power instruction seen while running
	sequence s_lp_go(logic e);
		e && cpu_clk_en && !rst_req;
	endsequence
	a_reset_vec: assert property (rst_req |=> int_start && int_vec == 16'hfffe && !push_pc_dec)
		else $error("reset entry not taken at top vector");
	a_swi_vec: assert property (s_swi_go |=> int_start && int_vec == 16'hfffc && !push_pc_dec)
		else $error("software entry missing or wrong");
	a_entry_mask: assert property (int_start |-> mask_bit)
		else $error("mask not set on entry");
	a_wait_gate: assert property (s_lp_go(wait_exec) |=> !cpu_clk_en && periph_clk_en && !mask_bit)
		else $error("wait entry clocks or mask wrong");
	a_stop_gate: assert property (s_lp_go(stop_exec) |=> !cpu_clk_en && !clk_x2_en && !periph_clk_en)
		else $error("stop entry left clocks running");
	a_x4_only_stop: assert property (!clk_x4_en |-> !clk_x2_en && !cpu_clk_en)
		else $error("fast clock gated outside stop");
	a_flag_guard: assert property (!break_state |-> flag_clr_ok)
		else $error("flag clearing blocked outside break");
	a_stat_zero: assert property (reg_rd && reg_addr == elp_pkg::OFS_STAT_ONE |=> reg_rdata[1:0] == 2'b00 && !reg_rdata[3])
		else $error("empty status bits read nonzero");
	a_hw_masked: assert property (int_start && push_pc_dec && int_vec != 16'hfffc |-> !$past(mask_bit, 2))
		else $error("hardware entry while masked");
endmodule // elp_ctrl_asserts

bind elp_ctrl elp_ctrl_asserts u_chk (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .rst_req(rst_req), .swi_exec(swi_exec), .wait_exec(wait_exec),
	.stop_exec(stop_exec), .int_start(int_start), .int_vec(int_vec), .push_pc_dec(push_pc_dec),
	.mask_bit(mask_bit), .break_state(break_state), .flag_clr_ok(flag_clr_ok), .cpu_clk_en(cpu_clk_en),
	.periph_clk_en(periph_clk_en), .clk_x2_en(clk_x2_en), .clk_x4_en(clk_x4_en));

// >>> sim/tb_top.sv
// self-checking bench for the exception and low-power control
// assumes package, interface and design files compiled first
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin n_fail++; \
	$display("[ERR] %s exp %h got %h", n, e, a); end end
module tb_top;
	localparam int REC = 40; // shortened long recovery
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:1] src_req = 15'h0000;
	logic [15:1] src_en = 15'h7fff;
	logic [6:0] p = 7'h00; // pulses: rst brk swi wait stop rti cli
	logic rti_mask = 1'b0;
	logic go = 1'b0;
	logic [7:0] reg_rdata, d;
	logic [15:0] int_vec;
	logic instr_done, int_start, push_pc_dec, mask_bit, break_state, flag_clr_ok;
	logic cpu_clk_en, periph_clk_en, clk_x2_en, clk_x4_en;
	int n_fail = 0;
	int compares = 0;
	int n_ent = 0;
	int n;
	// 25 MHz
	always #20 clk = ~clk;
	// entries seen, for checks that nothing was taken
	always @(posedge clk) if (int_start === 1'b1) n_ent++;
	elp_ctrl #(.STOP_REC_CYC(REC)) dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_req(src_req), .src_en(src_en),
		.rst_req(p[6]), .brk_req(p[5]), .instr_done(instr_done), .swi_exec(p[4]), .wait_exec(p[3]),
		.stop_exec(p[2]), .rti_exec(p[1]), .rti_mask(rti_mask), .cli_exec(p[0]), .int_start(int_start),
		.int_vec(int_vec), .push_pc_dec(push_pc_dec), .mask_bit(mask_bit), .break_state(break_state),
		.flag_clr_ok(flag_clr_ok), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
		.clk_x2_en(clk_x2_en), .clk_x4_en(clk_x4_en));
	elp_cpu_model cpu (.clk(clk), .nrst(nrst), .go(go), .cpu_clk_en(cpu_clk_en), .int_start(int_start),
		.instr_done(instr_done));
	// one-cycle strobe on a cpu event line
	task automatic pulse(int i);
		@(posedge clk);
		p[i] <= 1'b1;
		@(posedge clk);
		p[i] <= 1'b0;
		#1;
	endtask
	task automatic set_src(logic [15:1] r);
		@(posedge clk);
		src_req <= r;
		#1;
	endtask
	task automatic wr(logic [2:0] a, logic [7:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	// data stands only in the cycle after the strobe
	task automatic rd(logic [2:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	// bounded wait for an entry, then judge it
	task automatic ent(logic [15:0] v, logic pd);
		for (int i = 0; i < 300 && int_start !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		`CHK("start", 1'b1, int_start)
		`CHK("vec", v, int_vec)
		`CHK("pc dec", pd, push_pc_dec)
		`CHK("mask", 1'b1, mask_bit)
	endtask
	task automatic t_regs();
		`CHK("rst mask", 1'b1, mask_bit)
		set_src(15'h7fff);
		rd(3'h0);
		`CHK("stat1", 8'hf4, d)
		rd(3'h1);
		`CHK("stat2", 8'hfd, d)
		rd(3'h2);
		`CHK("stat3", 8'h01, d)
		set_src(15'h5555);
		wr(3'h0, 8'hff);
		rd(3'h0);
		`CHK("stat1 alt", 8'h54, d)
		rd(3'h1);
		`CHK("stat2 alt", 8'h55, d)
		set_src(15'h0000);
		rd(3'h2);
		`CHK("stat3 off", 8'h00, d)
		// control defaults and an unmapped word
		for (int a = 3; a < 7; a++) begin
			rd(a[2:0]);
			`CHK("dflt", 8'h00, d)
		end
	endtask
	task automatic t_hw();
		set_src(15'h0014); // sources 3 and 5 together
		pulse(0);
		ent(16'hfff6, 1'b1);
		set_src(15'h0010);
		n = n_ent;
		repeat (20) @(posedge clk);
		#1;
		`CHK("masked", n, n_ent)
		pulse(0);
		@(posedge clk iff (instr_done && !mask_bit));
		src_req <= 15'h0011; // higher source after the latch
		ent(16'hfff2, 1'b1);
		pulse(1); // return with mask clear
		ent(16'hfffa, 1'b1);
		set_src(15'h0000);
		// a pending source whose enable is clear never enters
		@(posedge clk);
		src_en <= 15'h7ffe;
		set_src(15'h0001);
		pulse(0);
		n = n_ent;
		repeat (20) @(posedge clk);
		#1;
		`CHK("disabled", n, n_ent)
		set_src(15'h0000);
		@(posedge clk);
		src_en <= 15'h7fff;
	endtask
	task automatic t_swi_rst();
		pulse(4);
		ent(16'hfffc, 1'b0);
		pulse(6);
		ent(16'hfffe, 1'b0);
	endtask
	task automatic t_brk();
		pulse(5);
		ent(16'hfffc, 1'b1);
		`CHK("brk", 1'b1, break_state)
		`CHK("guard", 1'b0, flag_clr_ok)
		wr(3'h3, 8'h80);
		`CHK("break_flag_clear_enable", 1'b1, flag_clr_ok)
		wr(3'h3, 8'h00);
		`CHK("guard back", 1'b0, flag_clr_ok)
		@(posedge clk);
		rti_mask <= 1'b1;
		pulse(1);
		`CHK("brk off", 1'b0, break_state)
		`CHK("rti mask", 1'b1, mask_bit)
		`CHK("guard off", 1'b1, flag_clr_ok)
	endtask
	task automatic t_wait();
		pulse(3);
		`CHK("cpu clk", 1'b0, cpu_clk_en)
		`CHK("per clk", 1'b1, periph_clk_en)
		`CHK("wmask", 1'b0, mask_bit)
		set_src(15'h0001);
		ent(16'hfffa, 1'b1);
		set_src(15'h0000);
		pulse(3);
		pulse(5);
		ent(16'hfffc, 1'b1);
		rd(3'h5); `CHK("break_stop_wait_flag", 1'b1, d[1])
		wr(3'h5, 8'h00);
		pulse(1);
		// reset also leaves wait
		pulse(3);
		pulse(6);
		ent(16'hfffe, 1'b0);
		`CHK("rst wake", 1'b1, cpu_clk_en)
	endtask
	// stop, wake by pin source, count recovery cycles
	task automatic t_stop(logic [7:0] cfg, int k, logic x4);
		wr(3'h4, cfg);
		pulse(2);
		`CHK("x2 off", 1'b0, clk_x2_en)
		`CHK("x4", x4, clk_x4_en)
		set_src(15'h0001);
		n = 0;
		while (cpu_clk_en !== 1'b1 && n < 5000) begin
			@(posedge clk);
			#1;
			n++;
		end
		`CHK("recov", 1'b1, n >= k && n <= k + 3)
		ent(16'hfffa, 1'b1);
		set_src(15'h0000);
	endtask
	task automatic end_sim();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		go <= 1'b1;
		t_regs();
		t_hw();
		t_swi_rst();
		t_brk();
		t_wait();
		t_stop(8'h01, 32, 1'b0);
		t_stop(8'h02, REC, 1'b1);
		end_sim();
	end
	// watchdog at 20000 cycles, well past the few hundred the sequence needs
	initial begin
		#(40 * 20000);
		n_fail++;
		end_sim();
	end
endmodule // tb_top
